/* sgd_pkg.sv */
// Purpose: Shared constants for the stepper gauge serial slave
// Assumes: 25 MHz core clock; internal oscillator emulated at 1 MHz
// Notes:   Register reset values are plain zeros
package sgd_pkg;
  // Word layout
  localparam int WORD_W  = 16;              // Serial word length
  localparam int ADDR_HI = 15;              // Address field top bit
  localparam int ADDR_LO = 13;              // Address field bottom bit
  localparam int DATA_W  = 13;              // Data field width
  localparam int CNT_W   = 4;               // Bit counter, mod 16
  localparam int NUM_REG = 6;               // Writable registers

  // Register addresses
  localparam logic [2:0] ADDR_PWR_EN_CAL = 3'h0; // power_enable_calib
  localparam logic [2:0] ADDR_MAX_VEL    = 3'h1; // max_velocity
  localparam logic [2:0] ADDR_GAUGE0_POS = 3'h2; // gauge0_position
  localparam logic [2:0] ADDR_GAUGE1_POS = 3'h3; // gauge1_position
  localparam logic [2:0] ADDR_RTZ        = 3'h4; // return_to_zero
  localparam logic [2:0] ADDR_RTZ_CONF   = 3'h5; // return_to_zero_confirm
  localparam logic [2:0] ADDR_UNUSED     = 3'h6; // Not used
  localparam logic [2:0] ADDR_TEST_RSVD  = 3'h7; // test_reserved

  // Reset value of every register
  localparam logic [12:0] REG_RST = 13'h0000;

  // Timing
  localparam int CORE_PERIOD_NS = 40;       // 25 MHz core clock
  localparam int OSC_PERIOD_NS  = 1000;     // Internal oscillator period
  localparam int OSC_DIV        = OSC_PERIOD_NS / CORE_PERIOD_NS;

  // Buffering
  localparam int FIFO_DEPTH = 4;            // Committed words in flight
endpackage

/* sgd_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module sgd_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;   // First stage, metastable
  logic [W-1:0] sync_r;   // Second stage, safe to use

  // Two stages; reset loads idle levels synchronously
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      meta_r <= rst_val_in;
      sync_r <= rst_val_in;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // sgd_sync

/* sgd_fifo.sv */
// Purpose: Small FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Depth must be a power of two
`timescale 1ns/1ns
module sgd_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sgd_fifo depth must be a power of two");
  end

  logic [W-1:0] mem_r [DEPTH];     // Storage
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;   // Occupancy, one extra bit
  logic          push, pop;

  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH)); // Honest full
  assign out_valid_out = (cnt_r != '0);             // Honest empty
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // Pointer and count next values
  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    cnt_nxt    = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Register pointers and store
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end
endmodule // sgd_fifo

/* sgd_spi_slave.sv */
// Purpose: Serial slave front end of a dual stepper gauge driver
// Assumes: Serial clock, select and input arrive from pins, asynchronous
// Notes:   Words commit at the oscillator tick rate, through a FIFO
//
// How it works
// RQ1 - Words are 16 bits, MSB first both ways
// RQ2 - Drive serial out only while select low
// RQ3 - Ignore clock and input while select high
// RQ4 - Select rising commits received word to register
// RQ5 - Master keeps clock low around select edges
// RQ6 - Sample input on falling clock, select low
// RQ7 - Output changes only on rising clock edges
// RQ8 - Partial-word frames are discarded whole
// RQ9 - Master raises select between words
// RQ10 - First rising edge loads status word
// RQ11 - Later bits echo received bits in order
// RQ12 - Bits 15 to 13 pick the register
// RQ13 - Codes 0-5 map registers; 6,7 ignored
// RQ14 - Master clocks only under select, 16 per word
// RQ15 - Master holds select high for commit time
// RQ16 - Synchronised select edge commits exactly once
`timescale 1ns/1ns
module sgd_spi_slave #(
  parameter int OSC_DIV    = sgd_pkg::OSC_DIV,
  parameter int FIFO_DEPTH = sgd_pkg::FIFO_DEPTH
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        sel_n_in,        // Chip select pin
  input  wire logic                        sclk_in,         // Serial clock pin
  input  wire logic                        sdi_in,          // Serial data in pin
  input  wire logic [sgd_pkg::WORD_W-1:0]  status_in,       // Status word
  output logic                             sdo_out,         // Serial data out
  output logic                             sdo_oe_out,      // Output enable
  output logic                             busy_out,        // Commit path full
  output logic [sgd_pkg::NUM_REG-1:0]      wr_stb_out,      // Register written
  output logic [sgd_pkg::DATA_W-1:0]       power_enable_calib_out,
  output logic [sgd_pkg::DATA_W-1:0]       max_velocity_out,
  output logic [sgd_pkg::DATA_W-1:0]       gauge0_position_out,
  output logic [sgd_pkg::DATA_W-1:0]       gauge1_position_out,
  output logic [sgd_pkg::DATA_W-1:0]       return_to_zero_out,
  output logic [sgd_pkg::DATA_W-1:0]       return_to_zero_confirm_out
);
  localparam int WW = sgd_pkg::WORD_W;
  localparam int DW = sgd_pkg::DATA_W;
  localparam int NR = sgd_pkg::NUM_REG;
  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

  // Refuse a divider that cannot tick
  if (OSC_DIV < 1) begin : g_chk
    $error("sgd_spi_slave OSC_DIV must be at least 1");
  end

  // ---------------- Pin synchronisers ----------------
  logic [2:0] pins_s;                 // {sel_n, sclk, sdi} synchronised
  logic       sel_n_s, sclk_s, sdi_s;

  sgd_sync #(.W(3)) u_sync (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .async_in    ({sel_n_in, sclk_in, sdi_in}),
    .rst_val_in  (3'h4),
    .sync_out    (pins_s)
  );
  assign sel_n_s = pins_s[2];
  assign sclk_s  = pins_s[1];
  assign sdi_s   = pins_s[0];

  // ---------------- Edge detection ----------------
  logic sel_n_d_r, sel_n_d_nxt;       // Previous select level
  logic sclk_d_r, sclk_d_nxt;         // Previous clock level
  logic sclk_rise, sclk_fall, sel_rise;
  logic active;                       // Select low: frame open

  // Edges read only the second sync stage and its copy
  always_comb begin
    sel_n_d_nxt = sel_n_s;
    sclk_d_nxt  = sclk_s;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sel_n_d_r <= 1'b1;
      sclk_d_r  <= 1'b0;
    end else begin
      sel_n_d_r <= sel_n_d_nxt;
      sclk_d_r  <= sclk_d_nxt;
    end
  end

  assign active    = !sel_n_s;
  assign sclk_rise = active & sclk_s & !sclk_d_r;    // RQ3
  assign sclk_fall = active & !sclk_s & sclk_d_r;    // RQ3
  assign sel_rise  = sel_n_s & !sel_n_d_r;           // RQ16

  // ---------------- Shift engine ----------------
  logic [WW-1:0]              rx_r, rx_nxt;        // Input shift register
  logic [WW-1:0]              tx_r, tx_nxt;        // Output queue
  logic [sgd_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;      // Bits mod 16
  logic                       got_word_r, got_word_nxt; // At least 16 bits
  logic                       first_r, first_nxt;  // Next rise is the first
  logic                       sdo_r, sdo_nxt;
  logic                       oe_r, oe_nxt;
  logic                       frame_ok;            // Whole words only

  assign frame_ok = got_word_r & (cnt_r == '0);    // RQ8

  // Next state of the shifters; rise then fall forms one bit
  always_comb begin
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    cnt_nxt      = cnt_r;
    got_word_nxt = got_word_r;
    first_nxt    = first_r;
    sdo_nxt      = sdo_r;
    oe_nxt       = active;                        // RQ2
    if (!active) begin
      // Idle: rearm for the next frame, shifters hold
      first_nxt = 1'b1;                            // RQ3
    end else if (sclk_rise) begin
      if (first_r) begin
        // Status goes out first, MSB leading
        sdo_nxt   = status_in[WW-1];               // RQ10
        tx_nxt    = {status_in[WW-2:0], 1'b0};     // RQ10
        first_nxt = 1'b0;
      end else begin
        // Queue head: status tail, then received bits in order
        sdo_nxt = tx_r[WW-1];                      // RQ7
        tx_nxt  = {tx_r[WW-2:0], 1'b0};            // RQ11
      end
    end else if (sclk_fall) begin
      rx_nxt    = {rx_r[WW-2:0], sdi_s};           // RQ6
      tx_nxt[0] = sdi_s;                           // RQ11
      cnt_nxt   = cnt_r + 1'b1;                    // RQ1
      if (cnt_r == '1) begin
        got_word_nxt = 1'b1;                       // RQ1
      end
    end
    if (sel_rise) begin
      // Frame ended: clear counting for the next one
      cnt_nxt      = '0;
      got_word_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rx_r       <= '0;
      tx_r       <= '0;
      cnt_r      <= '0;
      got_word_r <= 1'b0;
      first_r    <= 1'b1;
      sdo_r      <= 1'b0;
      oe_r       <= 1'b0;
    end else begin
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      cnt_r      <= cnt_nxt;
      got_word_r <= got_word_nxt;
      first_r    <= first_nxt;
      sdo_r      <= sdo_nxt;
      oe_r       <= oe_nxt;
    end
  end

  assign sdo_out    = sdo_r;
  assign sdo_oe_out = oe_r;

  // ---------------- Commit holding stage ----------------
  // Holds one word if the FIFO is full, so a burst is not lost
  logic [WW-1:0] pend_r, pend_nxt;
  logic          pend_vld_r, pend_vld_nxt;
  logic          fifo_in_ready;
  logic          busy_r, busy_nxt;

  always_comb begin
    pend_r_hold: begin
      pend_nxt     = pend_r;
      pend_vld_nxt = pend_vld_r;
    end
    if (pend_vld_r && fifo_in_ready) begin
      pend_vld_nxt = 1'b0;
    end
    if (sel_rise && frame_ok) begin
      // Last full word is ours; earlier ones pass downstream
      pend_nxt     = rx_r;                         // RQ4
      pend_vld_nxt = 1'b1;                         // RQ4
    end
    busy_nxt = pend_vld_nxt | !fifo_in_ready;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pend_r     <= '0;
      pend_vld_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      pend_r     <= pend_nxt;
      pend_vld_r <= pend_vld_nxt;
      busy_r     <= busy_nxt;
    end
  end

  assign busy_out = busy_r;

  // ---------------- Oscillator tick ----------------
  logic [DIV_W-1:0] div_r, div_nxt;
  logic             tick;                        // One cycle per oscillator period

  assign tick = (div_r == DIV_W'(OSC_DIV - 1));

  always_comb begin
    div_nxt = tick ? '0 : div_r + 1'b1;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ---------------- Commit FIFO ----------------
  logic          fifo_out_valid;
  logic [WW-1:0] fifo_out_data;
  logic          drain;

  // Drains only on the slow tick, so it can genuinely fill
  sgd_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_in   (core_clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (pend_vld_r),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_r),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (tick),
    .out_data_out  (fifo_out_data)
  );
  assign drain = fifo_out_valid & tick;

  // ---------------- Register file ----------------
  logic [DW-1:0] reg_r [NR];
  logic [DW-1:0] reg_nxt [NR];
  logic [NR-1:0] stb_r, stb_nxt;
  logic [2:0]    waddr;

  assign waddr = fifo_out_data[sgd_pkg::ADDR_HI:sgd_pkg::ADDR_LO]; // RQ12

  // Decode address; unused and test codes change nothing
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      reg_nxt[i] = reg_r[i];
    end
    stb_nxt = '0;
    if (drain) begin
      case (waddr)
        sgd_pkg::ADDR_PWR_EN_CAL,
        sgd_pkg::ADDR_MAX_VEL,
        sgd_pkg::ADDR_GAUGE0_POS,
        sgd_pkg::ADDR_GAUGE1_POS,
        sgd_pkg::ADDR_RTZ,
        sgd_pkg::ADDR_RTZ_CONF: begin
          reg_nxt[waddr] = fifo_out_data[DW-1:0];  // RQ13
          stb_nxt[waddr] = 1'b1;                   // RQ13
        end
        default: begin
          stb_nxt = '0;                            // RQ13
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < NR; i++) begin
        reg_r[i] <= sgd_pkg::REG_RST;
      end
      stb_r <= '0;
    end else begin
      for (int i = 0; i < NR; i++) begin
        reg_r[i] <= reg_nxt[i];
      end
      stb_r <= stb_nxt;
    end
  end

  assign wr_stb_out                 = stb_r;
  assign power_enable_calib_out     = reg_r[0];
  assign max_velocity_out           = reg_r[1];
  assign gauge0_position_out        = reg_r[2];
  assign gauge1_position_out        = reg_r[3];
  assign return_to_zero_out         = reg_r[4];
  assign return_to_zero_confirm_out = reg_r[5];

  // ---------------- Assertions ----------------
  a_out_hiz_idle: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ2
    sel_n_s |=> !sdo_oe_out) else $error("Serial out driven while deselected");

  a_ignore_idle: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ3
    (sel_n_s && !sel_rise) |=> ($stable(rx_r) && $stable(sdo_out))) else $error("Shift while deselected");

  a_sample_fall: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ6
    sclk_fall |=> (rx_r[0] == $past(sdi_s)) && (rx_r[WW-1:1] == $past(rx_r[WW-2:0])))
    else $error("Input not sampled on falling edge");

  a_out_on_rise: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ7
    $changed(sdo_out) |-> $past(sclk_rise)) else $error("Output changed off a rising edge");

  a_status_first: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ10
    (sclk_rise && first_r) |=> (sdo_out == $past(status_in[WW-1])) ##0 !first_r)
    else $error("Status MSB not presented first");

  a_drop_partial: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ8
    (sel_rise && !frame_ok && !pend_vld_r) |=> !pend_vld_r) else $error("Partial frame committed");

  a_commit_word: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ4
    (sel_rise && frame_ok) |=> pend_vld_r && (pend_r == $past(rx_r))) else $error("Word not captured");

  a_word_count: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ1
    (sclk_fall && cnt_r == 4'hf && !sel_rise) |=> (got_word_r && cnt_r == 4'h0))
    else $error("Word boundary not at 16 bits");

  a_addr_decode: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ12
    (drain && waddr == sgd_pkg::ADDR_MAX_VEL) |=>
      (wr_stb_out == 6'h02) && (max_velocity_out == $past(fifo_out_data[DW-1:0])))
    else $error("Address field misrouted");

  a_single_strobe: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ16
    (wr_stb_out != '0) |-> ($onehot(wr_stb_out) && $past(drain))) else $error("Multiple commits");

  a_test_ignored: assert property (@(posedge core_clk_in) disable iff (srst_in) // RQ13
    (drain && waddr[2:1] == 2'b11) |=> (wr_stb_out == '0)) else $error("Reserved code wrote a register");
endmodule // sgd_spi_slave

/* sgd_master_model.sv */
// Purpose: Behavioural serial bus master facing the gauge slave
// Assumes: Core clock paces every pin change; serial clock period 320 ns
// Notes:   Data lines have no pull, so a released line shows the inverse of its last level
`timescale 1ns/1ns
module sgd_master_model (
  input  wire logic core_clk_in, // Pacing clock
  input  wire logic sdo_in,      // Slave data out
  input  wire logic sdo_oe_in,   // Slave output enable
  output logic      sel_n_out,   // Chip select, idle high
  output logic      sclk_out,    // Serial clock, idle low
  output logic      sdi_out      // Serial data to slave
);
  logic so_line = 1'b0;          // Slave out as the master sees it

  // Idle levels at time zero
  initial begin
    sel_n_out = 1'b1;
    sclk_out  = 1'b0;
    sdi_out   = 1'b0;
  end

  // Wait n core cycles, landing just after the edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // One frame of n bits, MSB first; returns the bits seen on the way back
  task automatic xfer(input logic [63:0] d, input int n, output logic [63:0] rx, input int gap);
    rx = '0;
    sel_n_out = 1'b0;
    wt(4);
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out  = d[i];
      sclk_out = 1'b1;
      wt(4);
      sclk_out = 1'b0;
      wt(4);
      // A released pin has no pull, so it flips away from its last level
      so_line = sdo_oe_in ? sdo_in : ~so_line;
      rx      = {rx[62:0], so_line};
    end
    sel_n_out = 1'b1;
    sdi_out   = ~sdi_out;
    wt(gap);
  endtask

  // Clock and data noise while deselected; ends with clock low
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sdi_out  = ~sdi_out;
      sclk_out = 1'b1;
      wt(4);
      sclk_out = 1'b0;
      wt(4);
    end
  endtask
endmodule // sgd_master_model

/* test_stepper_gauge_spi_slave.sv */
// Purpose: Self-checking bench for the gauge serial slave and its buffer
// Assumes: Slow oscillator tick so a burst of frames fills the commit buffer
// Notes:   Driver notes expected commits; a watcher pops them on each strobe
`timescale 1ns/1ns
module test_stepper_gauge_spi_slave;
  localparam int OSC_DIV = 1000; // Slower than a burst of five frames, so the buffer fills

  logic        core_clk_in = 1'b0;  // 25 MHz clock
  logic        srst_in     = 1'b1;  // Held for 10 cycles
  logic [15:0] status_in   = 16'h0000; // Status word offered
  wire logic   sel_n, sclk, sdi;    // Master pins
  wire logic   sdo, sdo_oe, busy;   // Slave pins and flag
  wire logic [5:0]       wr_stb;    // Write strobes
  wire logic [5:0][12:0] regs;      // Register contents
  int          gap_cyc = 1020;      // Select-high gap; above one tick, so commits drain
  logic [15:0] exp_q [$];           // Expected commits, address and data
  logic [15:0] wexp;                // Commit being compared
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  sgd_spi_slave #(.OSC_DIV(OSC_DIV), .FIFO_DEPTH(sgd_pkg::FIFO_DEPTH)) i_dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .sel_n_in(sel_n), .sclk_in(sclk),
    .sdi_in(sdi), .status_in(status_in), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .busy_out(busy), .wr_stb_out(wr_stb), .power_enable_calib_out(regs[0]),
    .max_velocity_out(regs[1]), .gauge0_position_out(regs[2]), .gauge1_position_out(regs[3]),
    .return_to_zero_out(regs[4]), .return_to_zero_confirm_out(regs[5]));

  sgd_master_model i_master (
    .core_clk_in(core_clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
    .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi));

  // Free-running core clock
  always #20 core_clk_in = ~core_clk_in;

  // Compare and count; report a mismatch at once
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single verdict point for the whole run
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, above the roughly 22300 cycles the run needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // Watcher: every strobe must match the oldest noted commit; settled on the falling edge
  always @(negedge core_clk_in) begin
    if (!srst_in && wr_stb !== 6'h00) begin
      if (exp_q.size() == 0) begin
        check("unexpected write", wr_stb, 64'h0);
      end else begin
        wexp = exp_q.pop_front();
        check("write strobe", wr_stb, 6'h01 << wexp[15:13]);
        check("register data", regs[wexp[15:13]], wexp[12:0]);
      end
    end
  end

  // One 16-bit frame with a fresh status; commit noted unless the code writes nothing
  task automatic send(input logic [15:0] w);
    logic [63:0] rx;
    status_in = 16'($urandom);
    if (w[15:13] < 3'h6) exp_q.push_back(w);
    i_master.xfer({48'h0, w}, 16, rx, gap_cyc);
    check("status out", rx[15:0], status_in);
    check("output released", sdo_oe, 1'b0);
  endtask

  // Main sequence
  initial begin
    logic [63:0] rx;
    logic [15:0] w1;
    logic [15:0] w2;
    void'($urandom(3));
    i_master.wt(10);
    srst_in = 1'b0;
    i_master.wt(3);
    // Reset state
    for (int i = 0; i < 6; i++) check("reset value", regs[i], sgd_pkg::REG_RST);
    check("reset enable", sdo_oe, 1'b0);
    check("reset busy", busy, 1'b0);
    // Every address code, then boundary data values
    for (int a = 0; a < 8; a++) send({3'(a), 13'($urandom)});
    send({sgd_pkg::ADDR_GAUGE1_POS, 13'h1fff});
    send({sgd_pkg::ADDR_RTZ_CONF, 13'h0000});
    // Two words in one frame: only the last commits, the first is echoed
    w1 = {3'($urandom_range(5)), 13'($urandom)};
    w2 = {3'($urandom_range(5)), 13'($urandom)};
    status_in = 16'($urandom);
    exp_q.push_back(w2);
    i_master.xfer({32'h0, w1, w2}, 32, rx, gap_cyc);
    check("chain status", rx[31:16], status_in);
    check("chain echo", rx[15:0], w1);
    // Short and overlong frames are dropped
    i_master.xfer({48'h0, 16'($urandom)}, 15, rx, gap_cyc);
    i_master.xfer({47'h0, 17'($urandom)}, 17, rx, gap_cyc);
    // Noise while deselected, then a clean frame must still commit alone
    i_master.noise(20);
    send({sgd_pkg::ADDR_PWR_EN_CAL, 13'($urandom)});
    i_master.wt(50);
    check("pending writes", exp_q.size(), 64'h0);
    // Burst: five frames inside one tick period; the tick mid-burst drains one, four fill the buffer
    gap_cyc = 8;
    for (int i = 0; i < 5; i++) send({3'($urandom_range(5)), 13'($urandom)});
    check("burst busy", busy, 1'b1);
    gap_cyc = 1020;
    // Five ticks drain the burst in order through the watcher
    i_master.wt(5100);
    check("burst drained", exp_q.size(), 64'h0);
    check("busy after drain", busy, 1'b0);
    report_and_stop();
  end
endmodule // test_stepper_gauge_spi_slave
